/* logic/pet_pkg.sv */
// Shared constants and types for the PWM edge timing block.
// Assumes one 250 MHz clock and a byte-wide register port from the host.
package pet_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PET_THIRD_RISE_HIGH  = 8'h49;
  localparam logic [7:0] PET_THIRD_RISE_SET   = 8'h4a;
  localparam logic [7:0] PET_THIRD_FALL_HIGH  = 8'h4b;
  localparam logic [7:0] PET_THIRD_FALL_SET   = 8'h4c;
  localparam logic [7:0] PET_FOURTH_RISE_HIGH = 8'h4d;
  localparam logic [7:0] PET_FOURTH_RISE_SET  = 8'h4e;
  localparam logic [7:0] PET_FOURTH_FALL_HIGH = 8'h4f;
  localparam logic [7:0] PET_FOURTH_FALL_SET  = 8'h50;
  localparam logic [7:0] PET_RECT_RISE_HIGH   = 8'h51;
  localparam logic [7:0] PET_RECT_RISE_SET    = 8'h52;
  localparam logic [7:0] PET_REG_FIRST        = PET_THIRD_RISE_HIGH;
  localparam logic [7:0] PET_REG_LAST         = PET_RECT_RISE_SET;
  localparam int         PET_NUM_REGS         = 10;
  localparam logic [7:0] PET_REG_RESET        = 8'h00;

  // ----------------------------------------------------------------
  // Setting register fields
  // ----------------------------------------------------------------
  localparam int PET_TIME_LO_MSB = 7;
  localparam int PET_TIME_LO_LSB = 4;
  localparam int PET_MOD_EN_BIT  = 3;
  localparam int PET_SIGN_BIT    = 2;
  localparam int PET_TIME_W      = 12;

  // ----------------------------------------------------------------
  // Edge order and timing
  // ----------------------------------------------------------------
  localparam int PET_EDGE_THIRD_RISE  = 0;
  localparam int PET_EDGE_THIRD_FALL  = 1;
  localparam int PET_EDGE_FOURTH_RISE = 2;
  localparam int PET_EDGE_FOURTH_FALL = 3;
  localparam int PET_EDGE_RECT_RISE   = 4;
  localparam int PET_NUM_EDGES        = 5;
  localparam logic [3:0] PET_EDGE_RES_NS   = 4'h5;
  localparam logic [3:0] PET_CLK_PERIOD_NS = 4'h4;

  typedef struct packed {
    logic [PET_TIME_W-1:0] timeVal;
    logic                  modEn;
    logic                  modNeg;
  } pet_edge_s;

endpackage

/* logic/pet_edge_slot.sv */
// Effective time of one PWM edge after modulation is applied.
// Assumes the caller holds the edge settings stable for a whole period.
`timescale 1ns/1ns
module pet_edge_slot #(
  parameter int TIME_W = 12
) (
  input  wire pet_pkg::pet_edge_s   edgeCfg,
  input  wire logic [TIME_W-1:0]    modAmount,
  output logic      [TIME_W-1:0]    effTime
);
  import pet_pkg::*;

  logic [TIME_W:0] later;
  logic [TIME_W:0] earlier;

  // ----------------------------------------------------------------
  // Shift by modulation
  // ----------------------------------------------------------------
  // Both directions saturate so that a large modulation pins the edge
  // to the period start or the all-ones count instead of wrapping around.
  always_comb begin
    later   = {1'b0, edgeCfg.timeVal} + {1'b0, modAmount};
    earlier = {1'b0, edgeCfg.timeVal} - {1'b0, modAmount};
    if (!edgeCfg.modEn) begin
      effTime = edgeCfg.timeVal;
    end else if (edgeCfg.modNeg) begin
      effTime = later[TIME_W] ? '1 : later[TIME_W-1:0];
    end else begin
      effTime = earlier[TIME_W] ? '0 : earlier[TIME_W-1:0];
    end
  end

endmodule

/* logic/pet_edge_timing.sv */
// Edge timing registers and edge generation for two switch outputs and
// the rising edge of the first rectifier output.
// Assumes a 250 MHz clock, a byte register port and a modulation amount
// and period length supplied by the surrounding control loop.
//
// Notes on behaviour
// - Each edge time is timing register byte above setting bits 7..4.
// - One count of edge time equals 5 ns.
// - Setting bit 3 set moves the edge by the modulation amount.
// - Setting bit 2 set moves edge later with modulation, clear earlier.
// - Edge pairs drive third, fourth outputs and rectifier rise.
`timescale 1ns/1ns
module pet_edge_timing #(
  parameter int TIME_W = 12
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                regAddr,
  input  wire logic [7:0]                regWrData,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  output logic      [7:0]                regRdData,
  input  wire logic [TIME_W-1:0]         modAmount,
  input  wire logic [TIME_W-1:0]         periodCount,
  output logic                           thirdSwitchOutput,
  output logic                           fourthSwitchOutput,
  output logic                           firstRectifierOutput,
  output logic                           periodStart
);
  import pet_pkg::*;

  typedef struct packed {
    logic [PET_NUM_REGS-1:0][7:0]     regs;
    pet_edge_s [PET_NUM_EDGES-1:0]    edges;
    logic [TIME_W-1:0]                cnt;
    logic [3:0]                       acc;
    logic                             tick;
    logic                             thirdOut;
    logic                             fourthOut;
    logic                             rectOut;
    logic                             boundary;
    logic [7:0]                       rdData;
  } pet_state_s;

  pet_state_s st_r;
  pet_state_s st_nxt;

  logic [PET_NUM_EDGES-1:0][TIME_W-1:0] effTime;
  logic [PET_NUM_EDGES-1:0]             edgeHit;
  logic [3:0]                           accSum;
  logic                                 atEnd;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] addr);
    regHit = (addr >= PET_REG_FIRST) && (addr <= PET_REG_LAST);
  endfunction

  function automatic logic [3:0] regIdx(input logic [7:0] addr);
    logic [7:0] diff;
    diff   = addr - PET_REG_FIRST;
    regIdx = diff[3:0];
  endfunction

  // ----------------------------------------------------------------
  // Modulated edge times
  // ----------------------------------------------------------------
  for (genvar k = 0; k < PET_NUM_EDGES; k++) begin : g_slot
    pet_edge_slot #(
      .TIME_W    (TIME_W)
    ) u_slot (
      .edgeCfg   (st_r.edges[k]),
      .modAmount (modAmount),
      .effTime   (effTime[k])
    );
    assign edgeHit[k] = st_r.tick && (st_r.cnt == effTime[k]);
  end

  assign atEnd = st_r.tick && (st_r.cnt == periodCount);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // A 4 ns clock cannot step 5 ns exactly, so the edge tick fires on
    // four cycles of every five; edges carry up to 4 ns of jitter.
    accSum = st_r.acc + PET_CLK_PERIOD_NS;
    if (accSum >= PET_EDGE_RES_NS) begin
      st_nxt.tick = 1'b1;
      st_nxt.acc  = accSum - PET_EDGE_RES_NS;
    end else begin
      st_nxt.tick = 1'b0;
      st_nxt.acc  = accSum;
    end

    if (regWrEn && regHit(regAddr)) begin
      st_nxt.regs[regIdx(regAddr)] = regWrData;
    end
    if (regRdEn) begin
      st_nxt.rdData = regHit(regAddr) ? st_r.regs[regIdx(regAddr)] : 8'h00;
    end

    st_nxt.boundary = atEnd;
    if (st_r.tick) begin
      st_nxt.cnt = atEnd ? '0 : st_r.cnt + 1'b1;
    end
    // Shadow copies load only here, so a pair written within one period never shows half-written.
    if (atEnd) begin
      for (int k = 0; k < PET_NUM_EDGES; k++) begin
        st_nxt.edges[k].timeVal = {st_r.regs[2*k],
          st_r.regs[2*k+1][PET_TIME_LO_MSB:PET_TIME_LO_LSB]};
        st_nxt.edges[k].modEn  = st_r.regs[2*k+1][PET_MOD_EN_BIT];
        st_nxt.edges[k].modNeg = st_r.regs[2*k+1][PET_SIGN_BIT];
      end
    end

    // A fall that lands on the rise count wins and keeps the output low.
    if (edgeHit[PET_EDGE_THIRD_FALL]) begin
      st_nxt.thirdOut = 1'b0;
    end else if (edgeHit[PET_EDGE_THIRD_RISE]) begin
      st_nxt.thirdOut = 1'b1;
    end
    if (edgeHit[PET_EDGE_FOURTH_FALL]) begin
      st_nxt.fourthOut = 1'b0;
    end else if (edgeHit[PET_EDGE_FOURTH_RISE]) begin
      st_nxt.fourthOut = 1'b1;
    end
    // The rectifier fall edge lives elsewhere; here it ends with the period, but a rise on the end count wins.
    if (edgeHit[PET_EDGE_RECT_RISE]) begin
      st_nxt.rectOut = 1'b1;
    end else if (atEnd) begin
      st_nxt.rectOut = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.regs <= {PET_NUM_REGS{PET_REG_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData            = st_r.rdData;
  assign thirdSwitchOutput    = st_r.thirdOut;
  assign fourthSwitchOutput   = st_r.fourthOut;
  assign firstRectifierOutput = st_r.rectOut;
  assign periodStart          = st_r.boundary;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_time_pair;
    atEnd |=> st_r.edges[PET_EDGE_RECT_RISE].timeVal ==
      {$past(st_r.regs[8]),
       $past(st_r.regs[9][PET_TIME_LO_MSB:PET_TIME_LO_LSB])};
  endproperty
  a_time_pair: assert property (p_time_pair)
    else $error("Rectifier rise time not built from its register pair.");

  property p_tick_rate;
    $fell(st_r.tick) |=> st_r.tick [*4] ##1 !st_r.tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("Edge tick does not give four steps in five cycles.");

  property p_fixed_edge;
    !st_r.edges[PET_EDGE_THIRD_RISE].modEn |->
      effTime[PET_EDGE_THIRD_RISE] == st_r.edges[PET_EDGE_THIRD_RISE].timeVal;
  endproperty
  a_fixed_edge: assert property (p_fixed_edge)
    else $error("Unmodulated edge moved away from its fixed time.");

  property p_sign_dir;
    st_r.edges[PET_EDGE_THIRD_RISE].modEn && modAmount != '0 &&
      st_r.edges[PET_EDGE_THIRD_RISE].timeVal != '0 &&
      st_r.edges[PET_EDGE_THIRD_RISE].timeVal != '1 |->
      (st_r.edges[PET_EDGE_THIRD_RISE].modNeg ?
        effTime[PET_EDGE_THIRD_RISE] >
          st_r.edges[PET_EDGE_THIRD_RISE].timeVal :
        effTime[PET_EDGE_THIRD_RISE] <
          st_r.edges[PET_EDGE_THIRD_RISE].timeVal);
  endproperty
  a_sign_dir: assert property (p_sign_dir)
    else $error("Modulated edge moved the wrong way for its sign.");

  property p_third_rise;
    edgeHit[PET_EDGE_THIRD_RISE] && !edgeHit[PET_EDGE_THIRD_FALL] |=>
      thirdSwitchOutput;
  endproperty
  a_third_rise: assert property (p_third_rise)
    else $error("Third output did not rise at its rise count.");

  property p_fourth_fall;
    edgeHit[PET_EDGE_FOURTH_FALL] |=> !fourthSwitchOutput;
  endproperty
  a_fourth_fall: assert property (p_fourth_fall)
    else $error("Fourth output did not fall at its fall count.");

  property p_shadow_hold;
    !atEnd |=> $stable(st_r.edges);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("Edge settings changed inside a switching period.");

  property p_rect_rise;
    edgeHit[PET_EDGE_RECT_RISE] |=> firstRectifierOutput;
  endproperty
  a_rect_rise: assert property (p_rect_rise)
    else $error("Rectifier output did not rise at its rise count.");

  property p_period_mark;
    atEnd && !edgeHit[PET_EDGE_RECT_RISE] |=>
      periodStart && !firstRectifierOutput;
  endproperty
  a_period_mark: assert property (p_period_mark)
    else $error("Period boundary did not mark start or end rectifier pulse.");

endmodule

/* bench/pet_switch_model.sv */
// Behavioural model of the power-stage drivers fed by the edge outputs.
// Assumes the outputs are clean registered levels; widths are kept in ns.
`timescale 1ns/1ns
module pet_switch_model (
  input  wire logic thirdSwitchOutput,
  input  wire logic fourthSwitchOutput,
  input  wire logic firstRectifierOutput,
  output int        thirdWidth,
  output int        fourthWidth,
  output int        rectWidth
);
  realtime thirdRise;
  realtime fourthRise;
  realtime rectRise;

  // ----------------------------------------------------------------
  // Pulse width capture
  // ----------------------------------------------------------------
  // A width is only updated at a falling edge, so a pulse cut by reset
  // leaves a short value that a following check would expose.
  always @(posedge thirdSwitchOutput) thirdRise = $realtime;
  always @(posedge fourthSwitchOutput) fourthRise = $realtime;
  always @(posedge firstRectifierOutput) rectRise = $realtime;
  always @(negedge thirdSwitchOutput) thirdWidth = int'($realtime - thirdRise);
  always @(negedge fourthSwitchOutput)
    fourthWidth = int'($realtime - fourthRise);
  always @(negedge firstRectifierOutput)
    rectWidth = int'($realtime - rectRise);
endmodule

/* bench/pet_edge_timing_tb_top.sv */
// Self-checking bench for the PWM edge timing block.
// Assumes the design package and the switch driver model are compiled first.
`timescale 1ns/1ns
module pet_edge_timing_tb_top;
  import pet_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wData;
    logic [7:0] rExp;
  } pet_row_s;
  // Setting bytes keep bits 1..0 at zero.
  localparam pet_row_s ROWS [12] = '{
    '{8'h49, 8'h01, 8'h01}, '{8'h4a, 8'h20, 8'h20}, '{8'h4b, 8'h02, 8'h02},
    '{8'h4c, 8'h50, 8'h50}, '{8'h4d, 8'h00, 8'h00}, '{8'h4e, 8'h80, 8'h80},
    '{8'h4f, 8'h03, 8'h03}, '{8'h50, 8'h00, 8'h00}, '{8'h51, 8'h01, 8'h01},
    '{8'h52, 8'h40, 8'h40}, '{8'h48, 8'hff, 8'h00}, '{8'h53, 8'ha5, 8'h00}};
  logic        clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic [11:0] modAmount;
  logic [11:0] periodCount;
  logic        thirdSwitchOutput;
  logic        fourthSwitchOutput;
  logic        firstRectifierOutput;
  logic        periodStart;
  logic [7:0]  d;
  int          thirdWidth;
  int          fourthWidth;
  int          rectWidth;
  int          fails;
  int          samples_checked;
  realtime     t0;

  pet_edge_timing #(.TIME_W(12)) i_dut (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .modAmount(modAmount),
    .periodCount(periodCount), .thirdSwitchOutput(thirdSwitchOutput),
    .fourthSwitchOutput(fourthSwitchOutput),
    .firstRectifierOutput(firstRectifierOutput), .periodStart(periodStart));
  pet_switch_model i_drv (.thirdSwitchOutput(thirdSwitchOutput),
    .fourthSwitchOutput(fourthSwitchOutput),
    .firstRectifierOutput(firstRectifierOutput), .thirdWidth(thirdWidth),
    .fourthWidth(fourthWidth), .rectWidth(rectWidth));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Edges land on 4 ns ticks while counts are 5 ns, so allow two ticks.
  function automatic logic near(input int w, input int e);
    return (w >= e - 8) && (w <= e + 8);
  endfunction
  task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    #1 v = regRdData;
  endtask
  task automatic waitPer(input int n);
    repeat (n) @(posedge periodStart);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #40000;
    fails++;
    summarize;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    modAmount = 12'h000;
    periodCount = 12'h03f;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check({thirdSwitchOutput, fourthSwitchOutput, firstRectifierOutput,
              periodStart}, 4'h0);
    rdReg(PET_THIRD_RISE_HIGH, d);
    check(d, PET_REG_RESET);
    foreach (ROWS[i]) wrReg(ROWS[i].addr, ROWS[i].wData);
    foreach (ROWS[i]) begin
      rdReg(ROWS[i].addr, d);
      check(d, ROWS[i].rExp);
    end
    waitPer(3);
    check(near(thirdWidth, 95), 1'b1);
    check(near(fourthWidth, 200), 1'b1);
    check(near(rectWidth, 215), 1'b1);
    t0 = $realtime;
    waitPer(1);
    check(int'($realtime - t0), 320);
    wrReg(PET_THIRD_FALL_HIGH, 8'h03);
    @(negedge thirdSwitchOutput);
    #1 check(near(thirdWidth, 95), 1'b1);
    waitPer(2);
    check(near(thirdWidth, 175), 1'b1);
    @(posedge clk) modAmount <= 12'h003;
    wrReg(PET_THIRD_RISE_SET, 8'h28);
    waitPer(3);
    check(near(thirdWidth, 190), 1'b1);
    wrReg(PET_THIRD_RISE_SET, 8'h2c);
    waitPer(3);
    check(near(thirdWidth, 160), 1'b1);
    wrReg(PET_THIRD_RISE_SET, 8'h20);
    wrReg(PET_RECT_RISE_SET, 8'h48);
    @(posedge clk) modAmount <= 12'h020;
    waitPer(3);
    check(near(thirdWidth, 175), 1'b1);
    check(near(rectWidth, 315), 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({thirdSwitchOutput, fourthSwitchOutput, firstRectifierOutput,
              periodStart}, 4'h0);
    @(posedge clk) rst_n <= 1'b1;
    rdReg(PET_RECT_RISE_SET, d);
    check(d, PET_REG_RESET);
    summarize;
  end
endmodule
